// file: verilog/arm_matcher.sv
// arp/rarp access rule entry matcher with apb configuration
//
// Function
// - opcode kind demands an ARP, RARP or unknown opcode, or is ignored.
// - request/reply demands a request or a reply opcode, or is ignored.
// - sender address: ignored in Any mode, exact match in Host mode.
// - Network mode compares the sender address only on sender mask bits.
// - target address: ignored in Any mode, exact match in Host mode.
// - Network mode compares the target address only on target mask bits.
// - ARP frames: sender hw address checked equal or unequal to source MAC.
// - RARP frames: target hw address checked equal or unequal to source MAC.
// - length pair check demands or refuses hw length 6 with proto length 4.
// - the hardware space check demands or refuses hardware type 1.
// - the protocol space check demands or refuses protocol type 0x800.
//
// Register map, one 32-bit word each, byte addressed:
//   0x00 control word of nine two-bit selectors, bits 31:18 read zero
//   0x04 sender address
//   0x08 sender mask
//   0x0c target address
//   0x10 target mask
//   0x14 status, read only: [15:0] match count, [16] live verdict
//        of the frame fields now on the inputs; any write clears the count
//   other offsets answer with an error, read zero and ignore writes
// Control word selectors:
//   [1:0] opcode kind: 0 any, 1 ARP, 2 RARP, 3 unknown opcode
//   [3:2] request/reply: 0 any, 1 request, 2 reply, 3 any
//   [5:4] sender address, [7:6] target address: 0 any, 1 host,
//        2 network, 3 any
//   [9:8] sender hw equals source, [11:10] target hw equals source,
//   [13:12] length pair, [15:14] hw type, [17:16] protocol type:
//        0 any, 1 must be false, 2 must be true, 3 any
// Reset leaves every selector at any, so every frame matches.
// Timing:
//   the bus never inserts wait states; read data is captured in the
//   setup cycle and stands until the next setup cycle
//   result_valid_o follows frame_valid_i by one clock, and the verdict
//   uses the control word as it stood when the frame was taken
//   a match and a status clear in one cycle leave the count at zero
`timescale 1ns/100ps
module arm_matcher
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // parsed frame in
   input wire logic frame_valid_i,
   input wire logic [47:0] frame_smac_i,
   input wire logic [15:0] frame_hrd_i,
   input wire logic [15:0] frame_pro_i,
   input wire logic [7:0] frame_hln_i,
   input wire logic [7:0] frame_pln_i,
   input wire logic [15:0] frame_op_i,
   input wire logic [47:0] frame_sha_i,
   input wire logic [31:0] frame_spa_i,
   input wire logic [47:0] frame_tha_i,
   input wire logic [31:0] frame_tpa_i,
   // verdict
   output logic result_valid_o,
   output logic result_match_o
);

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed
   {
      logic [31:0] ctrl;
      logic [31:0] spa;
      logic [31:0] spa_mask;
      logic [31:0] tpa;
      logic [31:0] tpa_mask;
      logic [15:0] match_cnt;
      logic [31:0] prdata;
      logic res_valid;
      logic res_match;
   } arm_state_type;

   arm_state_type state_q;
   arm_state_type state_d;

   ////////////////////////////////////////////////////////////////////////////
   // three-way check: any, must be false, must be true
   function automatic logic tri_ok(input logic [1:0] sel, input logic cond);
      logic ok;
      ok = 1'b1;
      if (sel == arm_pkg::TRI_ZERO)
      begin
         ok = !cond;
      end
      else if (sel == arm_pkg::TRI_ONE)
      begin
         ok = cond;
      end
      return ok;
   endfunction

   // protocol address filter in any, host or network mode
   function automatic logic pa_ok(input logic [1:0] mode,
                                  input logic [31:0] addr,
                                  input logic [31:0] cfg,
                                  input logic [31:0] mask);
      logic ok;
      ok = 1'b1;
      if (mode == arm_pkg::PA_HOST)
      begin
         ok = (addr == cfg);
      end
      else if (mode == arm_pkg::PA_NETWORK)
      begin
         ok = ((addr & mask) == (cfg & mask));
      end
      return ok;
   endfunction

   // true only for the six offsets that hold a register
   function automatic logic addr_mapped(input logic [7:0] addr);
      logic hit;
      hit = 1'b0;
      unique case (addr)
         arm_pkg::ADDR_CTRL, arm_pkg::ADDR_SPA, arm_pkg::ADDR_SPA_MASK,
         arm_pkg::ADDR_TPA, arm_pkg::ADDR_TPA_MASK, arm_pkg::ADDR_STATUS:
            hit = 1'b1;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // opcode decode
   logic is_arp_req;
   logic is_arp_rep;
   logic is_rarp_req;
   logic is_rarp_rep;
   logic is_arp;
   logic is_rarp;
   logic is_unknown;
   assign is_arp_req = (frame_op_i == arm_pkg::OP_ARP_REQ);
   assign is_arp_rep = (frame_op_i == arm_pkg::OP_ARP_REP);
   assign is_rarp_req = (frame_op_i == arm_pkg::OP_RARP_REQ);
   assign is_rarp_rep = (frame_op_i == arm_pkg::OP_RARP_REP);
   // frame kind from the opcode
   assign is_arp = is_arp_req | is_arp_rep;
   assign is_rarp = is_rarp_req | is_rarp_rep;
   assign is_unknown = !(is_arp | is_rarp);

   // configuration fields
   logic [1:0] opkind_sel;
   logic [1:0] reqrep_sel;
   logic [1:0] spa_mode;
   logic [1:0] tpa_mode;
   logic [1:0] sender_hw_equals_source_check;
   logic [1:0] target_hw_equals_source_check;
   logic [1:0] length_pair_check;
   logic [1:0] hrd_check;
   logic [1:0] pro_check;
   // selectors sliced out of the control word
   assign opkind_sel = state_q.ctrl[arm_pkg::CTRL_OPKIND_LSB +: 2];
   assign reqrep_sel = state_q.ctrl[arm_pkg::CTRL_REQREP_LSB +: 2];
   assign spa_mode = state_q.ctrl[arm_pkg::CTRL_SPA_LSB +: 2];
   assign tpa_mode = state_q.ctrl[arm_pkg::CTRL_TPA_LSB +: 2];
   assign sender_hw_equals_source_check =
      state_q.ctrl[arm_pkg::CTRL_SHA_LSB +: 2];
   assign target_hw_equals_source_check =
      state_q.ctrl[arm_pkg::CTRL_THA_LSB +: 2];
   assign length_pair_check = state_q.ctrl[arm_pkg::CTRL_LEN_LSB +: 2];
   assign hrd_check = state_q.ctrl[arm_pkg::CTRL_HRD_LSB +: 2];
   assign pro_check = state_q.ctrl[arm_pkg::CTRL_PRO_LSB +: 2];

   ////////////////////////////////////////////////////////////////////////////
   // per-criterion verdicts
   logic ok_opkind;
   logic ok_reqrep;
   logic ok_spa;
   logic ok_tpa;
   logic ok_sha;
   logic ok_tha;
   logic ok_len;
   logic ok_hrd;
   logic ok_pro;
   logic all_ok;

   always_comb
   begin
      // opcode kind: any, ARP, RARP or unknown
      unique case (opkind_sel)
         arm_pkg::OPK_ARP: ok_opkind = is_arp;
         arm_pkg::OPK_RARP: ok_opkind = is_rarp;
         arm_pkg::OPK_OTHER: ok_opkind = is_unknown;
         default: ok_opkind = 1'b1;
      endcase
      // code 3 of request/reply is treated as any
      unique case (reqrep_sel)
         arm_pkg::RR_REQUEST: ok_reqrep = is_arp_req | is_rarp_req;
         arm_pkg::RR_REPLY: ok_reqrep = is_arp_rep | is_rarp_rep;
         default: ok_reqrep = 1'b1;
      endcase
   end

   assign ok_spa = pa_ok(spa_mode, frame_spa_i, state_q.spa, state_q.spa_mask);
   assign ok_tpa = pa_ok(tpa_mode, frame_tpa_i, state_q.tpa, state_q.tpa_mask);
   // hardware address checks apply only to their own frame kind
   assign ok_sha = !is_arp ||
      tri_ok(sender_hw_equals_source_check, frame_sha_i == frame_smac_i);
   assign ok_tha = !is_rarp ||
      tri_ok(target_hw_equals_source_check, frame_tha_i == frame_smac_i);
   assign ok_len = tri_ok(length_pair_check,
      (frame_hln_i == arm_pkg::HLN_ETHERNET) &&
      (frame_pln_i == arm_pkg::PLN_IPV4));
   assign ok_hrd = tri_ok(hrd_check,
      frame_hrd_i == arm_pkg::HRD_ETHERNET);
   assign ok_pro = tri_ok(pro_check, frame_pro_i == arm_pkg::PRO_IPV4);
   // every criterion must hold together
   assign all_ok = ok_opkind & ok_reqrep & ok_spa & ok_tpa & ok_sha &
      ok_tha & ok_len & ok_hrd & ok_pro;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   logic apb_setup;
   logic apb_write;
   logic mapped;
   assign apb_setup = psel_i & !penable_i;
   assign apb_write = psel_i & penable_i & pwrite_i;
   assign mapped = addr_mapped(paddr_i);

   // next state
   always_comb
   begin
      // hold everything unless a frame or a bus access moves it
      state_d = state_q;
      // verdict pulse for the frame taken at this edge
      state_d.res_valid = frame_valid_i;
      state_d.res_match = frame_valid_i & all_ok;
      // count matches; a status clear in the same cycle wins below
      if (frame_valid_i && all_ok)
      begin
         state_d.match_cnt = 16'(state_q.match_cnt + 16'h0001);
      end
      // read data captured in setup, presented in access
      if (apb_setup)
      begin
         unique case (paddr_i)
            arm_pkg::ADDR_CTRL: state_d.prdata = state_q.ctrl;
            arm_pkg::ADDR_SPA: state_d.prdata = state_q.spa;
            arm_pkg::ADDR_SPA_MASK: state_d.prdata = state_q.spa_mask;
            arm_pkg::ADDR_TPA: state_d.prdata = state_q.tpa;
            arm_pkg::ADDR_TPA_MASK: state_d.prdata = state_q.tpa_mask;
            arm_pkg::ADDR_STATUS:
               state_d.prdata = {15'h0000, all_ok, state_q.match_cnt};
            default: state_d.prdata = 32'h0000_0000;
         endcase
      end
      // writes land at the access edge; unmapped offsets change nothing
      if (apb_write)
      begin
         unique case (paddr_i)
            arm_pkg::ADDR_CTRL: state_d.ctrl =
               {14'h0000, pwdata_i[arm_pkg::CTRL_WIDTH-1:0]};
            arm_pkg::ADDR_SPA: state_d.spa = pwdata_i;
            arm_pkg::ADDR_SPA_MASK: state_d.spa_mask = pwdata_i;
            arm_pkg::ADDR_TPA: state_d.tpa = pwdata_i;
            arm_pkg::ADDR_TPA_MASK: state_d.tpa_mask = pwdata_i;
            arm_pkg::ADDR_STATUS: state_d.match_cnt = 16'h0000;
            default: state_d.ctrl = state_q.ctrl;
         endcase
      end
   end

   // state register
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         // all fields zero, control word to its reset value
         state_q <= '0;
         state_q.ctrl <= arm_pkg::CTRL_RESET;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign prdata_o = state_q.prdata;
   assign pready_o = 1'b1; // zero wait states
   assign pslverr_o = psel_i & penable_i & !mapped;
   // registered verdict pulse
   assign result_valid_o = state_q.res_valid;
   assign result_match_o = state_q.res_match;

endmodule

// file: verilog/arm_pkg.sv
// constants for the arp access rule matcher
package arm_pkg;
   // apb register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SPA = 8'h04;
   localparam logic [7:0] ADDR_SPA_MASK = 8'h08;
   localparam logic [7:0] ADDR_TPA = 8'h0c;
   localparam logic [7:0] ADDR_TPA_MASK = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   // control field positions, each field two bits wide
   localparam int CTRL_OPKIND_LSB = 0;
   localparam int CTRL_REQREP_LSB = 2;
   localparam int CTRL_SPA_LSB = 4;
   localparam int CTRL_TPA_LSB = 6;
   localparam int CTRL_SHA_LSB = 8;
   localparam int CTRL_THA_LSB = 10;
   localparam int CTRL_LEN_LSB = 12;
   localparam int CTRL_HRD_LSB = 14;
   localparam int CTRL_PRO_LSB = 16;
   localparam int CTRL_WIDTH = 18;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // opcode kind settings
   localparam logic [1:0] OPK_ANY = 2'h0;
   localparam logic [1:0] OPK_ARP = 2'h1;
   localparam logic [1:0] OPK_RARP = 2'h2;
   localparam logic [1:0] OPK_OTHER = 2'h3;
   // request/reply settings
   localparam logic [1:0] RR_ANY = 2'h0;
   localparam logic [1:0] RR_REQUEST = 2'h1;
   localparam logic [1:0] RR_REPLY = 2'h2;
   // protocol address modes
   localparam logic [1:0] PA_ANY = 2'h0;
   localparam logic [1:0] PA_HOST = 2'h1;
   localparam logic [1:0] PA_NETWORK = 2'h2;
   // tri-state check settings
   localparam logic [1:0] TRI_ANY = 2'h0;
   localparam logic [1:0] TRI_ZERO = 2'h1;
   localparam logic [1:0] TRI_ONE = 2'h2;
   // frame field values
   localparam logic [15:0] OP_ARP_REQ = 16'h0001;
   localparam logic [15:0] OP_ARP_REP = 16'h0002;
   localparam logic [15:0] OP_RARP_REQ = 16'h0003;
   localparam logic [15:0] OP_RARP_REP = 16'h0004;
   localparam logic [7:0] HLN_ETHERNET = 8'h06;
   localparam logic [7:0] PLN_IPV4 = 8'h04;
   localparam logic [15:0] HRD_ETHERNET = 16'h0001;
   localparam logic [15:0] PRO_IPV4 = 16'h0800;
endpackage

// file: dv/arm_matcher_monitor.sv
// port-level checks on the arp rule matcher
`timescale 1ns/100ps
module arm_matcher_monitor
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic frame_valid_i,
   input wire logic [15:0] frame_op_i,
   input wire logic [7:0] frame_hln_i,
   input wire logic [7:0] frame_pln_i,
   input wire logic [15:0] frame_hrd_i,
   input wire logic [15:0] frame_pro_i,
   input wire logic result_valid_o,
   input wire logic result_match_o
);
   logic [17:0] ctl_q;
   logic wr_ctl;
   // shadow of the control word; a write lands at the access edge
   assign wr_ctl = psel_i && penable_i && pwrite_i && paddr_i == 8'h00;
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         ctl_q <= '0;
      else if (wr_ctl)
         ctl_q <= pwdata_i[17:0];
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence miss_s; ##1 !result_match_o; endsequence
   sequence frm_s; frame_valid_i; endsequence
   valid_lat_a: assert property (frm_s |=> result_valid_o)
      else $error("verdict pulse missing");
   no_spur_a: assert property (!frame_valid_i |=> !result_valid_o)
      else $error("verdict without frame");
   match_qual_a: assert property (result_match_o |-> result_valid_o)
      else $error("match outside verdict");
   kind_arp_a: assert property (frm_s ##0 ctl_q[1:0] == 2'h1 &&
      !(frame_op_i inside {16'h0001, 16'h0002}) |-> miss_s)
      else $error("non arp opcode matched");
   kind_other_a: assert property (frm_s ##0 ctl_q[1:0] == 2'h3 &&
      frame_op_i inside {[16'h0001:16'h0004]} |-> miss_s)
      else $error("known opcode matched other");
   reply_only_a: assert property (frm_s ##0 ctl_q[3:2] == 2'h2 &&
      !(frame_op_i inside {16'h0002, 16'h0004}) |-> miss_s)
      else $error("non reply matched");
   len_pair_a: assert property (frm_s ##0 ctl_q[13:12] == 2'h2 &&
      (frame_hln_i != 8'h06 || frame_pln_i != 8'h04) |-> miss_s)
      else $error("length pair ignored");
   hw_space_a: assert property (frm_s ##0 ctl_q[15:14] == 2'h1 &&
      frame_hrd_i == 16'h0001 |-> miss_s)
      else $error("hardware space ignored");
   pro_space_a: assert property (frm_s ##0 ctl_q[17:16] == 2'h2 &&
      frame_pro_i != 16'h0800 |-> miss_s)
      else $error("protocol space ignored");
   all_any_a: assert property (frm_s ##0 ctl_q == '0 |=> result_match_o)
      else $error("open entry missed");
   apb_ready_a: assert property (psel_i && penable_i |-> pready_o)
      else $error("access not ready");
   err_resp_a: assert property (psel_i && penable_i |-> pslverr_o ==
      !(paddr_i inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14}))
      else $error("error response wrong");
endmodule
bind arm_matcher arm_matcher_monitor mon_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
   .pslverr_o(pslverr_o),
   .frame_valid_i(frame_valid_i), .frame_op_i(frame_op_i),
   .frame_hln_i(frame_hln_i), .frame_pln_i(frame_pln_i),
   .frame_hrd_i(frame_hrd_i), .frame_pro_i(frame_pro_i),
   .result_valid_o(result_valid_o), .result_match_o(result_match_o));

// file: dv/arm_frame_src.sv
// parsed-frame source standing in for the switch ports
`timescale 1ns/100ps
module arm_frame_src
(
   input wire logic clk_i,
   output logic valid_o,
   output logic [47:0] smac_o,
   output logic [47:0] sha_o,
   output logic [47:0] tha_o,
   output logic [15:0] hrd_o,
   output logic [15:0] pro_o,
   output logic [15:0] op_o,
   output logic [7:0] hln_o,
   output logic [7:0] pln_o,
   output logic [31:0] spa_o,
   output logic [31:0] tpa_o
);
   initial {valid_o, smac_o, sha_o, tha_o, hrd_o, pro_o} = '0;
   initial {op_o, hln_o, pln_o, spa_o, tpa_o} = '0;
   function automatic bit coin();
      return 1'($urandom_range(0, 1));
   endfunction
   // launch one frame, fields often near the entry so criteria hit
   task automatic send(input logic [31:0] sp, input logic [31:0] tp);
      logic [47:0] m;
      m = {16'($urandom), $urandom};
      valid_o <= 1'h1;
      smac_o <= m;
      sha_o <= coin() ? m : ~m;
      tha_o <= coin() ? m : {m[46:0], 1'h1};
      hrd_o <= coin() ? arm_pkg::HRD_ETHERNET : 16'($urandom);
      pro_o <= coin() ? arm_pkg::PRO_IPV4 : 16'($urandom);
      hln_o <= coin() ? arm_pkg::HLN_ETHERNET : 8'($urandom);
      pln_o <= coin() ? arm_pkg::PLN_IPV4 : 8'($urandom);
      op_o <= 16'($urandom_range(0, 5));
      spa_o <= coin() ? sp : sp ^ (32'h1 << $urandom_range(0, 31));
      tpa_o <= coin() ? tp : tp ^ (32'h1 << $urandom_range(0, 31));
   endtask
   // one-cycle pulse; stale fields are inverted so nothing reuses them
   always @(posedge clk_i)
      if (valid_o)
      begin
         valid_o <= 1'h0;
         {smac_o, sha_o, tha_o} <= ~{smac_o, sha_o, tha_o};
         {hrd_o, pro_o, op_o, spa_o} <= ~{hrd_o, pro_o, op_o, spa_o};
         {hln_o, pln_o, tpa_o} <= ~{hln_o, pln_o, tpa_o};
      end
endmodule

// file: dv/arm_matcher_tb.sv
// self-checking bench for the arp rule matcher
`timescale 1ns/100ps
module arm_matcher_tb;
   logic clk = '0, rst_n = '0, psel = '0, pen = '0, pwr = '0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd, v[5];
   logic pready, perr, err, fv, rv, rm, e;
   logic [47:0] smac, sha, tha;
   logic [15:0] hrd, pro, op;
   logic [7:0] hln, pln;
   logic [31:0] spa, tpa;
   int bad_count = 0, checks_done = 0, cyc = 0, hits = 0;
   arm_frame_src src_u (.clk_i(clk), .valid_o(fv), .smac_o(smac),
      .sha_o(sha), .tha_o(tha), .hrd_o(hrd), .pro_o(pro), .op_o(op),
      .hln_o(hln), .pln_o(pln), .spa_o(spa), .tpa_o(tpa));
   arm_matcher dut_u (.clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
      .frame_valid_i(fv), .frame_smac_i(smac), .frame_hrd_i(hrd),
      .frame_pro_i(pro), .frame_hln_i(hln), .frame_pln_i(pln),
      .frame_op_i(op), .frame_sha_i(sha), .frame_spa_i(spa),
      .frame_tha_i(tha), .frame_tpa_i(tpa), .result_valid_o(rv),
      .result_match_o(rm));
   initial forever #12.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      psel <= 1'h1;
      pen <= 1'h0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) @(posedge clk);
      rd = prdata;
      err = perr;
      psel <= 1'h0;
      pen <= 1'h0;
      @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   function automatic logic ok3(logic [1:0] s, logic c);
      return s == arm_pkg::TRI_ZERO ? !c : s == arm_pkg::TRI_ONE ? c : 1'h1;
   endfunction
   function automatic logic okpa(logic [1:0] s, logic [31:0] a, c, m);
      return s == arm_pkg::PA_HOST ? a == c :
         s == arm_pkg::PA_NETWORK ? ((a ^ c) & m) == '0 : 1'h1;
   endfunction
   // verdict expected from the written entry and the frame on the wires
   function automatic logic want();
      logic arp, rarp;
      logic [17:0] c;
      c = v[0][17:0];
      arp = op == 16'h1 || op == 16'h2;
      rarp = op == 16'h3 || op == 16'h4;
      return (c[1:0] == 2'h1 ? arp : c[1:0] == 2'h2 ? rarp
         : c[1:0] == 2'h3 ? !(arp || rarp) : 1'h1)
         && (c[3:2] == 2'h1 ? op == 16'h1 || op == 16'h3
         : c[3:2] == 2'h2 ? op == 16'h2 || op == 16'h4 : 1'h1)
         && okpa(c[5:4], spa, v[1], v[2]) && okpa(c[7:6], tpa, v[3], v[4])
         && (!arp || ok3(c[9:8], sha == smac))
         && (!rarp || ok3(c[11:10], tha == smac))
         && ok3(c[13:12], hln == 8'h06 && pln == 8'h04)
         && ok3(c[15:14], hrd == 16'h0001)
         && ok3(c[17:16], pro == 16'h0800);
   endfunction
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 12000)
      begin
         bad_count++;
         summarize();
      end
   end
   initial
   begin
      void'($urandom(98));
      v = '{5{32'h0}};
      repeat (8) @(posedge clk);
      rst_n <= 1'h1;
      apb(1'h0, arm_pkg::ADDR_CTRL, '0);
      chk(rd, 32'h0);
      apb(1'h1, 8'h18, 32'hffff_ffff);
      apb(1'h0, 8'h18, '0);
      chk({rd[30:0], err}, 32'h1);
      for (int n = 0; n < 600; n++)
      begin
         // new random entry every 40 frames; the first 40 use the open one
         if (n % 40 == 0 && n > 0)
         begin
            v = '{$urandom, $urandom, '1 << $urandom_range(0, 32),
               $urandom, '1 << $urandom_range(0, 32)};
            for (int i = 0; i < 5; i++) apb(1'h1, 8'(4 * i), v[i]);
            for (int i = 0; i < 5; i++)
            begin
               apb(1'h0, 8'(4 * i), '0);
               chk(rd, i == 0 ? v[0] & 32'h0003_ffff : v[i]);
            end
            v[0] = v[0] & 32'h0003_ffff;
         end
         src_u.send(v[1], v[3]);
         @(negedge clk);
         e = want();
         if (e === 1'h1)
            hits++;
         @(negedge clk);
         chk({30'h0, rv, rm}, {30'h0, 1'h1, e});
         @(posedge clk);
      end
      // status holds the match count and the live verdict; a write clears
      e = want();
      apb(1'h0, arm_pkg::ADDR_STATUS, '0);
      chk(rd, {15'h0, e, 16'(hits)});
      chk({31'h0, err}, 32'h0);
      apb(1'h1, arm_pkg::ADDR_STATUS, '0);
      apb(1'h0, arm_pkg::ADDR_STATUS, '0);
      chk(rd, {15'h0, e, 16'h0});
      summarize();
   end
endmodule
